// [core/gpio_irq_status_control.v]
// event flags, masks, de-bounce and general pin control behind an apb slave
//
// Behaviour
// - lock event flag bit 8, write-one clears
// - sticky flags: pin8 bit7, pin7 bit6, gpin bit0
// - function codes 0000-0101 and 0111 select pin behaviour
// - codes 1000-1011 route bias detects; others reserved
// - config bit 5 pull-up, resets off
// - config bit 4 pull-down, resets on
// - function field resets to input
// - de-bounce enables at bits 15, 14, 13
// - de-bounce enables at bits 11, 10, 9
// - de-bounce enables at bits 8, 7
// - de-bounce enables at bits 3, 0
// - mixer bit 6 drives input pad clamp
// - masks for bias-two at bits 13, 12
// - masks for temp, bias-one at 11, 10, 9
// - mask 1 suppresses source, resets to 0
// - read-only combined status at bit 12
// - masks: lock 8, pin8 6, gpin 5, pin7 2
// - per-source polarity: 0 high, 1 low triggers
`timescale 1ns/1ps
`include "gpio_irq_map.vh"

module gpio_irq_status_control #(
    parameter DEB_CYCLES = 16,
    parameter CNT_W = 5
) (
    // clock and reset
    input wire REF_CLK,
    input wire RST_N,
    // apb slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    // event sources
    input wire BIAS_ONE_CURRENT,
    input wire BIAS_ONE_SHORT,
    input wire BIAS_TWO_CURRENT,
    input wire BIAS_TWO_SHORT,
    input wire TEMPERATURE_OK,
    input wire LOCK,
    input wire SEQ_BUSY,
    input wire INPUT_PIN_SEVEN,
    input wire INPUT_PIN_EIGHT,
    input wire OUTPUT_CLOCK,
    // general pin
    input wire GENERAL_PIN_I,
    output reg GENERAL_PIN_O,
    output reg GENERAL_PIN_OE,
    output reg GENERAL_PIN_PULLUP,
    output reg GENERAL_PIN_PULLDOWN,
    // misc controls
    output reg INPUT_CLAMP,
    output reg IRQ_OUT
);

    reg [15:0] flags;
    reg [15:0] cfg;
    reg [15:0] deb;
    reg [15:0] mix;
    reg [15:0] msk;
    reg [15:0] pol;
    wire [15:0] filt;
    wire [15:0] src;
    wire [15:0] deb_ev;
    wire [15:0] msk_ev;
    wire [15:0] active;
    wire [5:0] idx;
    wire addr_ok;
    wire setup;
    wire wr_acc;
    reg [15:0] next_rdata;
    reg next_err;
    reg [15:0] next_flags;
    reg next_pin_o;
    reg next_pin_oe;
    reg irq_raw;

    // filter end count; DEB_CYCLES above 2**CNT_W truncates the end count, so the filter lands early
    localparam integer DEB_LAST_I = DEB_CYCLES - 1;
    localparam [CNT_W-1:0] DEB_LAST = DEB_LAST_I[CNT_W-1:0];
    // slots that carry a source, and the idle level each filter starts from
    localparam [15:0] EV_USED = `EVENT_BITS;
    localparam [15:0] POL_INIT = `POLARITY_RESET;

    // sources gathered into the event status layout
    assign src[`EV_B2_SHORT] = BIAS_TWO_SHORT;
    assign src[`EV_B2_CURRENT] = BIAS_TWO_CURRENT;
    assign src[`EV_SEQ] = SEQ_BUSY;
    assign src[`EV_IRQ] = 1'b0;
    assign src[`EV_TEMP] = TEMPERATURE_OK;
    assign src[`EV_B1_SHORT] = BIAS_ONE_SHORT;
    assign src[`EV_B1_CURRENT] = BIAS_ONE_CURRENT;
    assign src[`EV_LOCK] = LOCK;
    assign src[`EV_PIN8] = INPUT_PIN_EIGHT;
    assign src[`EV_PIN7] = INPUT_PIN_SEVEN;
    assign src[5:1] = 5'h0_0;
    assign src[`EV_GPIN] = GENERAL_PIN_I;

    // de-bounce enables moved into the event layout
    assign deb_ev[15:13] = deb[15:13];
    assign deb_ev[`EV_IRQ] = 1'b0;
    assign deb_ev[11:7] = deb[11:7];
    assign deb_ev[`EV_PIN7] = deb[`DB_PIN7];
    assign deb_ev[5:1] = 5'h0_0;
    assign deb_ev[`EV_GPIN] = deb[`EV_GPIN];

    // masks moved into the event layout
    assign msk_ev[`EV_B2_SHORT] = msk[`MK_B2_SHORT];
    assign msk_ev[`EV_B2_CURRENT] = msk[`MK_B2_CURRENT];
    assign msk_ev[`EV_SEQ] = msk[`MK_SEQ];
    assign msk_ev[`EV_IRQ] = 1'b1;
    assign msk_ev[`EV_TEMP] = msk[`MK_TEMP];
    assign msk_ev[`EV_B1_SHORT] = msk[`MK_B1_SHORT];
    assign msk_ev[`EV_B1_CURRENT] = msk[`MK_B1_CURRENT];
    assign msk_ev[`EV_LOCK] = msk[`MK_LOCK];
    assign msk_ev[`EV_PIN8] = msk[`MK_PIN8];
    assign msk_ev[`EV_PIN7] = msk[`MK_PIN7];
    assign msk_ev[5:1] = 5'h1F;
    assign msk_ev[`EV_GPIN] = msk[`MK_GPIN];

    // per-source filter; a disabled filter passes the level through
    genvar i;
    generate
        for (i = 0; i < 16; i = i + 1) begin : g_src
            if (EV_USED[i]) begin : g_on
                reg [CNT_W-1:0] cnt;
                reg hold;
                // hold starts at the idle level of its source, so that the
                // first edge after reset raises no false event
                // counter restarts on every bounce so only a held level lands
                always @(posedge REF_CLK or negedge RST_N) begin
                    if (!RST_N) begin
                        cnt <= {CNT_W{1'b0}};
                        hold <= POL_INIT[i];
                    end else if (!deb_ev[i] || src[i] == hold) begin
                        cnt <= {CNT_W{1'b0}};
                        hold <= src[i];
                    end else if (cnt == DEB_LAST) begin
                        cnt <= {CNT_W{1'b0}};
                        hold <= src[i];
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                assign filt[i] = hold;
            end else begin : g_off
                // unused slots carry no source and never set a flag
                assign filt[i] = 1'b0;
            end
        end
    endgenerate

    // polarity picks the triggering level of each source
    assign active = (filt ^ pol) & `EVENT_BITS;

    // apb decode: register index is the word address
    assign idx = PADDR[7:2];
    assign setup = PSEL && !PENABLE;
    assign wr_acc = PSEL && PENABLE && PREADY && PWRITE;
    assign addr_ok = (PADDR[1:0] == 2'b00) &&
        (idx >= `IDX_EVENT_STATUS) && (idx <= `IDX_POLARITY);

    // read mux, captured in setup so the access phase answers at once
    always @* begin
        next_err = !addr_ok;
        if (idx == `IDX_EVENT_STATUS) begin
            next_rdata = flags;
            next_rdata[`EV_IRQ] = IRQ_OUT;
        end else if (idx == `IDX_PIN_CONFIG) begin
            next_rdata = cfg;
        end else if (idx == `IDX_DEBOUNCE) begin
            next_rdata = deb;
        end else if (idx == `IDX_MIXER_ONE) begin
            next_rdata = mix;
        end else if (idx == `IDX_MASK_CONTROL) begin
            next_rdata = msk;
        end else if (idx == `IDX_POLARITY) begin
            next_rdata = pol;
        end else begin
            next_rdata = `ZERO_RESET;
        end
        if (!addr_ok) begin
            next_rdata = `ZERO_RESET;
        end
    end

    // bus answer: one wait-free access phase per transfer
    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0000_0000;
        end else if (setup) begin
            PREADY <= 1'b1;
            PSLVERR <= next_err;
            PRDATA <= {16'h0000, next_rdata};
        end else begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0000_0000;
        end
    end

    // control registers; only defined bits store
    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cfg <= `CONFIG_RESET;
            deb <= `ZERO_RESET;
            mix <= `ZERO_RESET;
            msk <= `ZERO_RESET;
            pol <= `POLARITY_RESET;
        end else if (wr_acc && addr_ok) begin
            if (idx == `IDX_PIN_CONFIG) begin
                cfg <= PWDATA[15:0] & `CONFIG_BITS;
            end else if (idx == `IDX_DEBOUNCE) begin
                deb <= PWDATA[15:0] & `DEBOUNCE_BITS;
            end else if (idx == `IDX_MIXER_ONE) begin
                mix <= PWDATA[15:0] & `MIXER_BITS;
            end else if (idx == `IDX_MASK_CONTROL) begin
                msk <= PWDATA[15:0] & `MASK_BITS;
            end else if (idx == `IDX_POLARITY) begin
                pol <= PWDATA[15:0] & `POLARITY_BITS;
            end
        end
    end

    // sticky flags: a new event wins over a write-one clear
    always @* begin
        next_flags = flags;
        if (wr_acc && addr_ok && idx == `IDX_EVENT_STATUS) begin
            next_flags = flags & ~(PWDATA[15:0] & `EVENT_BITS);
        end
        next_flags = next_flags | active;
    end

    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            flags <= `ZERO_RESET;
        end else begin
            flags <= next_flags;
        end
    end

    // combined interrupt from unmasked flags, then polarity
    always @* begin
        irq_raw = |(flags & ~msk_ev);
    end

    // general pin source by function code
    always @* begin
        next_pin_oe = 1'b1;
        case (cfg[`CFG_FUNC_HI:0])
            `FN_INPUT: begin
                next_pin_oe = 1'b0;
                next_pin_o = 1'b0;
            end
            `FN_OUT_CLOCK: next_pin_o = OUTPUT_CLOCK;
            `FN_LOW: next_pin_o = 1'b0;
            `FN_HIGH: next_pin_o = 1'b1;
            `FN_LOCK: next_pin_o = LOCK;
            `FN_TEMP_OK: next_pin_o = TEMPERATURE_OK;
            `FN_IRQ: next_pin_o = irq_raw ^ pol[`EV_IRQ];
            `FN_B1_CURRENT: next_pin_o = BIAS_ONE_CURRENT;
            `FN_B1_SHORT: next_pin_o = BIAS_ONE_SHORT;
            `FN_B2_CURRENT: next_pin_o = BIAS_TWO_CURRENT;
            `FN_B2_SHORT: next_pin_o = BIAS_TWO_SHORT;
            default: begin
                // reserved codes leave the pin undriven, safest for the board
                next_pin_oe = 1'b0;
                next_pin_o = 1'b0;
            end
        endcase
    end

    // every output leaves from a flop; pin paths lag one cycle
    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            GENERAL_PIN_O <= 1'b0;
            GENERAL_PIN_OE <= 1'b0;
            GENERAL_PIN_PULLUP <= 1'b0;
            GENERAL_PIN_PULLDOWN <= 1'b1;
            INPUT_CLAMP <= 1'b0;
            IRQ_OUT <= 1'b0;
        end else begin
            GENERAL_PIN_O <= next_pin_o;
            GENERAL_PIN_OE <= next_pin_oe;
            GENERAL_PIN_PULLUP <= cfg[`CFG_PULLUP];
            GENERAL_PIN_PULLDOWN <= cfg[`CFG_PULLDOWN];
            INPUT_CLAMP <= mix[`MIX_CLAMP];
            IRQ_OUT <= irq_raw ^ pol[`EV_IRQ];
        end
    end

endmodule // gpio_irq_status_control

// [inc/gpio_irq_map.vh]
// register map, field positions and reset values of the pin and event block
`ifndef GPIO_IRQ_MAP_VH
`define GPIO_IRQ_MAP_VH
// register indices; byte address is four times the index
`define IDX_EVENT_STATUS 6'h12
`define IDX_PIN_CONFIG 6'h13
`define IDX_DEBOUNCE 6'h14
`define IDX_MIXER_ONE 6'h15
`define IDX_MASK_CONTROL 6'h16
`define IDX_POLARITY 6'h17
// writable or defined bits per register
`define EVENT_BITS 16'hEFC1
`define CONFIG_BITS 16'h003F
`define DEBOUNCE_BITS 16'hEF89
`define MIXER_BITS 16'h0040
`define MASK_BITS 16'h3F77
`define POLARITY_BITS 16'hFFC1
// reset values
`define CONFIG_RESET 16'h0010
`define POLARITY_RESET 16'h0800
`define ZERO_RESET 16'h0000
// event status layout (also polarity layout)
`define EV_B2_SHORT 15
`define EV_B2_CURRENT 14
`define EV_SEQ 13
`define EV_IRQ 12
`define EV_TEMP 11
`define EV_B1_SHORT 10
`define EV_B1_CURRENT 9
`define EV_LOCK 8
`define EV_PIN8 7
`define EV_PIN7 6
`define EV_GPIN 0
// pin configuration fields
`define CFG_PULLUP 5
`define CFG_PULLDOWN 4
`define CFG_FUNC_HI 3
// de-bounce positions that differ from the event layout
`define DB_PIN7 3
// mask register positions
`define MK_B2_CURRENT 13
`define MK_B2_SHORT 12
`define MK_TEMP 11
`define MK_B1_SHORT 10
`define MK_B1_CURRENT 9
`define MK_LOCK 8
`define MK_PIN8 6
`define MK_GPIN 5
`define MK_PIN7 2
`define MK_SEQ 1
// input pad clamp in mixer register
`define MIX_CLAMP 6
// general pin function codes
`define FN_INPUT 4'h0
`define FN_OUT_CLOCK 4'h1
`define FN_LOW 4'h2
`define FN_HIGH 4'h3
`define FN_LOCK 4'h4
`define FN_TEMP_OK 4'h5
`define FN_IRQ 4'h7
`define FN_B1_CURRENT 4'h8
`define FN_B1_SHORT 4'h9
`define FN_B2_CURRENT 4'hA
`define FN_B2_SHORT 4'hB
`endif

// [verif/gpio_irq_chk.sv]
// port assertions for the pin and event block
`timescale 1ns/1ps
module gpio_irq_chk (
    // clock, reset and apb
    input wire REF_CLK,
    input wire RST_N,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PRDATA,
    input wire PREADY,
    input wire PSLVERR,
    // pin and controls
    input wire GENERAL_PIN_O,
    input wire GENERAL_PIN_OE,
    input wire GENERAL_PIN_PULLUP,
    input wire INPUT_CLAMP,
    input wire IRQ_OUT
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    // decoded setup and completed writes
    wire setup = PSEL && !PENABLE;
    wire ok = PADDR[1:0] == 2'b00 && PADDR[7:2] >= 6'h12 && PADDR[7:2] <= 6'h17;
    wire done_wr = PSEL && PENABLE && PREADY && PWRITE;
    ready_one_a: assert property (PREADY |=> !PREADY)
        else $error("pready longer than one cycle");
    ready_cause_a: assert property (PREADY |-> $past(setup))
        else $error("pready without setup");
    good_addr_a: assert property (setup && ok |=> PREADY && !PSLVERR)
        else $error("mapped access not answered cleanly");
    bad_addr_a: assert property (setup && !ok |=> PREADY && PSLVERR && PRDATA == 32'h0)
        else $error("unmapped access not refused");
    rdata_idle_a: assert property (!PREADY |-> PRDATA == 32'h0 && !PSLVERR)
        else $error("read bus not idle");
    // a copy may lag its register, so one or two edges are allowed
    pullup_write_a: assert property ($changed(GENERAL_PIN_PULLUP) |->
        $past(done_wr && PADDR == 8'h4C) || $past(done_wr && PADDR == 8'h4C, 2))
        else $error("pull-up moved without a write");
    clamp_write_a: assert property ($changed(INPUT_CLAMP) |->
        $past(done_wr && PADDR == 8'h54) || $past(done_wr && PADDR == 8'h54, 2))
        else $error("clamp moved without a write");
    irq_status_a: assert property (PREADY && !PWRITE && PADDR == 8'h48 |->
        PRDATA[12] == $past(IRQ_OUT))
        else $error("status bit differs from interrupt");
    pin_idle_a: assert property (!GENERAL_PIN_OE |-> !GENERAL_PIN_O)
        else $error("pin value while not driven");
endmodule // gpio_irq_chk

bind gpio_irq_status_control gpio_irq_chk chk_u (.REF_CLK(REF_CLK), .RST_N(RST_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .GENERAL_PIN_O(GENERAL_PIN_O),
    .GENERAL_PIN_OE(GENERAL_PIN_OE), .GENERAL_PIN_PULLUP(GENERAL_PIN_PULLUP),
    .INPUT_CLAMP(INPUT_CLAMP), .IRQ_OUT(IRQ_OUT));

// [verif/test_gpio_irq_status_control.sv]
// self-checking bench for the pin and event block
`timescale 1ns/1ps
`include "gpio_irq_map.vh"
module test_gpio_irq_status_control;
    // clock, reset and apb master
    logic REF_CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, rd;
    logic err;
    wire [31:0] PRDATA;
    wire PREADY, PSLVERR, o, oe, pu, pd, clamp, irq;
    // sources: b1c b1s b2c b2s temp lock seq pin7 pin8 outclk, pin input on top
    logic [10:0] src = 11'h010;
    int n_fail = 0, checks = 0;
    gpio_irq_status_control #(.DEB_CYCLES(4), .CNT_W(5)) dut_u (.REF_CLK(REF_CLK),
        .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .BIAS_ONE_CURRENT(src[0]), .BIAS_ONE_SHORT(src[1]), .BIAS_TWO_CURRENT(src[2]),
        .BIAS_TWO_SHORT(src[3]), .TEMPERATURE_OK(src[4]), .LOCK(src[5]),
        .SEQ_BUSY(src[6]), .INPUT_PIN_SEVEN(src[7]), .INPUT_PIN_EIGHT(src[8]),
        .OUTPUT_CLOCK(src[9]), .GENERAL_PIN_I(src[10]), .GENERAL_PIN_O(o),
        .GENERAL_PIN_OE(oe), .GENERAL_PIN_PULLUP(pu), .GENERAL_PIN_PULLDOWN(pd),
        .INPUT_CLAMP(clamp), .IRQ_OUT(irq));
    always #2 REF_CLK = ~REF_CLK;
    task end_sim;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // outputs read right after an edge still hold the value seen at it
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge REF_CLK);
        PSEL <= 1;
        PENABLE <= 0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1;
        n = 0;
        do begin
            @(posedge REF_CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        if (n >= 20) chk("pready", 1, 0);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 0;
        PENABLE <= 0;
    endtask
    task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    task cyc(input int n);
        repeat (n) @(posedge REF_CLK);
    endtask
    task t_reset;
        rdchk("status", 8'h48, 32'h0);
        rdchk("config", 8'h4C, `CONFIG_RESET);
        rdchk("debounce", 8'h50, 32'h0);
        rdchk("mixer", 8'h54, 32'h0);
        rdchk("mask", 8'h58, 32'h0);
        rdchk("polarity", 8'h5C, `POLARITY_RESET);
        chk("pins", 5'b00010, {o, oe, pu, pd, clamp});
        $display("test reset done");
    endtask
    task t_rw;
        logic [7:0] a[4] = '{8'h4C, 8'h50, 8'h54, 8'h58};
        logic [15:0] m[4] = '{`CONFIG_BITS, `DEBOUNCE_BITS, `MIXER_BITS, `MASK_BITS};
        for (int i = 0; i < 4; i++) begin
            apb(1, a[i], 32'hFFFF_FFFF);
            rdchk("rw", a[i], m[i]);
        end
        cyc(2);
        chk("pu clamp", 2'b11, {pu, clamp});
        for (int i = 0; i < 4; i++) apb(1, a[i], i == 0 ? `CONFIG_RESET : 32'h0);
        apb(1, 8'h60, 32'h0000_FFFF);
        chk("err", 1, err);
        apb(0, 8'h4A, 32'h0);
        chk("err rd", 1, err);
        chk("rd refused", 32'h0, rd);
        $display("test registers done");
    endtask
    // each source against its mask and its status bit
    task t_mask;
        int s[10] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 10};
        int m[10] = '{9, 10, 13, 12, 11, 8, 1, 2, 6, 5};
        int f[10] = '{9, 10, 14, 15, 11, 8, 13, 6, 7, 0};
        for (int i = 0; i < 10; i++) begin
            apb(1, 8'h58, 32'h1 << m[i]);
            src[s[i]] <= ~src[s[i]];
            cyc(6);
            chk("masked irq", 0, irq);
            rdchk("flag", 8'h48, 32'h1 << f[i]);
            apb(1, 8'h58, 32'h0);
            cyc(3);
            chk("open irq", 1, irq);
            src[s[i]] <= ~src[s[i]];
            cyc(4);
            apb(1, 8'h48, 32'h0000_FFFF);
            cyc(4);
            chk("cleared irq", 0, irq);
        end
        $display("test masks done");
    endtask
    task t_sticky;
        src[8] <= 1;
        cyc(2);
        src[8] <= 0;
        src[5] <= 1;
        cyc(3);
        src[5] <= 0;
        cyc(4);
        rdchk("sticky", 8'h48, 32'h1180);
        apb(1, 8'h48, 32'h0000_0000);
        rdchk("no clear", 8'h48, 32'h1180);
        apb(1, 8'h48, 32'h0000_0100);
        rdchk("lock clear", 8'h48, 32'h1080);
        apb(1, 8'h48, 32'h0000_0080);
        rdchk("all clear", 8'h48, 32'h0);
        $display("test sticky done");
    endtask
    task t_deb;
        apb(1, 8'h50, 32'h0000_0100);
        // three cycles is one short of the filter length and must be dropped
        src[5] <= 1;
        cyc(3);
        src[5] <= 0;
        cyc(8);
        rdchk("short pulse", 8'h48, 32'h0);
        // four cycles is exactly the filter length and must land
        src[5] <= 1;
        cyc(4);
        src[5] <= 0;
        cyc(10);
        rdchk("long pulse", 8'h48, 32'h0000_1100);
        apb(1, 8'h48, 32'h0000_FFFF);
        apb(1, 8'h50, 32'h0);
        $display("test filter done");
    endtask
    task t_pol;
        apb(1, 8'h5C, 32'h0000_1840);
        cyc(5);
        chk("low irq", 0, irq);
        rdchk("pin7 low", 8'h48, 32'h0040);
        apb(1, 8'h5C, 32'h0000_1800);
        apb(1, 8'h48, 32'h0000_FFFF);
        cyc(4);
        chk("idle irq", 1, irq);
        $display("test polarity done");
    endtask
    // all masked with low-active interrupt, so code 0111 drives 1
    task t_func;
        logic [15:0] eo = 16'h05BA;
        logic [15:0] ee = 16'h0FBE;
        apb(1, 8'h58, `MASK_BITS);
        src <= 11'h235;
        for (int c = 0; c < 16; c++) begin
            apb(1, 8'h4C, 32'h0000_0020 | c);
            cyc(3);
            chk("pin", {ee[c], eo[c]}, {oe, o});
        end
        // output clock code must follow its source, not sit high
        apb(1, 8'h4C, 32'h0000_0021);
        src[9] <= 1'b0;
        cyc(3);
        chk("clock pin", 2'b10, {oe, o});
        chk("pulls", 2'b10, {pu, pd});
        $display("test pin done");
    endtask
    initial begin
        repeat (4) @(posedge REF_CLK);
        RST_N <= 1;
        t_reset;
        t_rw;
        t_mask;
        t_sticky;
        t_deb;
        t_pol;
        t_func;
        end_sim;
    end
    initial begin
        #40000;
        n_fail++;
        end_sim;
    end
endmodule // test_gpio_irq_status_control
